// ---- rtl/cmd_status_pkg.sv ----
package cmd_status_pkg;
   localparam int WORD_W      = 32;
   localparam int HALF_W      = 16;
   // Fixed command half bit positions
   localparam int CMD_RUN     = 0;
   localparam int CMD_DIR     = 1;
   localparam int CMD_CLEAR   = 2;
   localparam int CMD_DIN_LO  = 3;
   localparam int CMD_DIN_HI  = 7;
   localparam int CMD_CTRL    = 8;
   localparam int CMD_REF     = 9;
   localparam int CMD_JOG1    = 10;
   localparam int CMD_JOG2    = 11;
   localparam int CMD_QSTOP   = 12;
   localparam int DIN_N       = 5;
   // Fixed report half bit positions
   localparam int RPT_READY   = 0;
   localparam int RPT_RUN     = 1;
   localparam int RPT_DIR     = 2;
   localparam int RPT_FAULT   = 3;
   localparam int RPT_ALARM   = 4;
   localparam int RPT_ATREF   = 5;
   localparam int RPT_ZERO    = 6;
   localparam int RPT_MAG     = 7;
   localparam int RPT_FLAGS   = 8;
   // Reset values
   localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
   localparam logic [HALF_W-1:0] HALF_RST = 16'h0000;
endpackage

// ---- rtl/drive_report_if.sv ----
`timescale 1ns/10ps
interface drive_report_if;
   import cmd_status_pkg::*;
   logic [RPT_FLAGS-1:0] flags;
   logic [HALF_W-1:0]    app;
   logic [WORD_W-1:0]    word;
   modport src (output flags, output app, input word);
   modport dst (input flags, input app, output word);
endinterface

// ---- rtl/report_word_builder.sv ----
`timescale 1ns/10ps
module report_word_builder
   import cmd_status_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst,
   drive_report_if.dst    rpt
);
   // Reserved bits B8..B15 of the fixed half forced to zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rpt.word <= WORD_RST;
      end else begin
         rpt.word <= {rpt.app, {(HALF_W-RPT_FLAGS){1'b0}}, rpt.flags};
      end
   end
endmodule

// ---- rtl/drive_command_status_word.sv ----
`timescale 1ns/10ps
module drive_command_status_word
   import cmd_status_pkg::*;
#(
   parameter int DIN_COUNT = DIN_N
)
(
   input  wire logic                 CLK_SYS,
   input  wire logic                 RST,
   input  wire logic [WORD_W-1:0]    COMMAND_WORD,
   input  wire logic                 COMMAND_VALID,
   input  wire logic                 ALT_VARIANT,
   input  wire logic                 DRIVE_READY,
   input  wire logic                 MOTOR_RUNNING,
   input  wire logic                 MOTOR_CCW,
   input  wire logic                 FAULT_ACTIVE,
   input  wire logic                 ALARM_ACTIVE,
   input  wire logic                 AT_REFERENCE,
   input  wire logic                 ZERO_SPEED,
   input  wire logic                 MAGNETIZED,
   input  wire logic [HALF_W-1:0]    APPLICATION_REPORT_HALF,
   output logic                      RUN_REQUEST,
   output logic                      REVERSE_REQUEST,
   output logic                      EVENT_CLEAR,
   output logic                      STOP_COAST,
   output logic                      STOP_RAMP,
   output logic                      QUICK_RAMP,
   output logic                      FREEZE_SETPOINT,
   output logic                      SETPOINT_ZERO,
   output logic                      FIELDBUS_CONTROL,
   output logic                      FIELDBUS_REFERENCE,
   output logic                      JOG_REFERENCE_FIRST,
   output logic                      JOG_REFERENCE_SECOND,
   output logic                      QUICK_STOP,
   output logic [DIN_COUNT-1:0]      REMOTE_INPUTS,
   output logic [HALF_W-1:0]         APPLICATION_COMMAND_HALF,
   output logic [WORD_W-1:0]         STATUS_WORD
);

   // Only the fixed half is decoded; the application half is forwarded whole
   logic [HALF_W-1:0] fixed_command_half;
   logic              clear_level_reg;
   logic              alt_reg;

   drive_report_if rpt_if ();

   // Low half as offered; only acted on while COMMAND_VALID is high
   assign fixed_command_half = COMMAND_WORD[HALF_W-1:0];

   // Variant strap caught after reset release, not under reset
   // Single flop: the strap is a level driven from this clock domain
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         alt_reg <= 1'b0;
      end else begin
         alt_reg <= ALT_VARIANT;
      end
   end

   // Previous clear level; held between words so a steady 1 never repeats
   // Idle cycles do not count as a 0, so the edge is judged word to word
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         clear_level_reg <= 1'b0;
      end else if (COMMAND_VALID) begin
         clear_level_reg <= fixed_command_half[CMD_CLEAR];
      end
   end

   // One-cycle clear pulse on rising edge only
   // A master that leaves bit 2 high gets exactly one clear
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         EVENT_CLEAR <= 1'b0;
      end else begin
         EVENT_CLEAR <= COMMAND_VALID && fixed_command_half[CMD_CLEAR]
                        && !clear_level_reg;
      end
   end

   // Run request level, held until the next taken word
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         RUN_REQUEST <= 1'b0;
      end else if (COMMAND_VALID) begin
         RUN_REQUEST <= fixed_command_half[CMD_RUN];
      end
   end

   // Requested direction level
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         REVERSE_REQUEST <= 1'b0;
      end else if (COMMAND_VALID) begin
         REVERSE_REQUEST <= fixed_command_half[CMD_DIR];
      end
   end

   // Control place override level
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         FIELDBUS_CONTROL <= 1'b0;
      end else if (COMMAND_VALID) begin
         FIELDBUS_CONTROL <= fixed_command_half[CMD_CTRL];
      end
   end

   // Setpoint source override level
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         FIELDBUS_REFERENCE <= 1'b0;
      end else if (COMMAND_VALID) begin
         FIELDBUS_REFERENCE <= fixed_command_half[CMD_REF];
      end
   end

   // Jog request with the first jog reference
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         JOG_REFERENCE_FIRST <= 1'b0;
      end else if (COMMAND_VALID) begin
         JOG_REFERENCE_FIRST <= fixed_command_half[CMD_JOG1];
      end
   end

   // Jog request with the second jog reference
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         JOG_REFERENCE_SECOND <= 1'b0;
      end else if (COMMAND_VALID) begin
         JOG_REFERENCE_SECOND <= fixed_command_half[CMD_JOG2];
      end
   end

   // Quick stop is a level; the drive decides how long to act on it
   // Dropping the bit lets normal operation resume on the next word
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         QUICK_STOP <= 1'b0;
      end else if (COMMAND_VALID) begin
         QUICK_STOP <= fixed_command_half[CMD_QSTOP];
      end
   end

   // Application half passed through untouched
   // Reserved bits 13..15 sit at the top of the fixed half and feed nothing
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         APPLICATION_COMMAND_HALF <= HALF_RST;
      end else if (COMMAND_VALID) begin
         APPLICATION_COMMAND_HALF <= COMMAND_WORD[WORD_W-1:HALF_W];
      end
   end

   // Bits 3..7 mean stop options or remote inputs, never both at once
   // The variant flop, not the raw strap, picks the meaning
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         STOP_COAST      <= 1'b0;
         STOP_RAMP       <= 1'b0;
         QUICK_RAMP      <= 1'b0;
         FREEZE_SETPOINT <= 1'b0;
         SETPOINT_ZERO   <= 1'b0;
         REMOTE_INPUTS   <= '0;
      end else if (COMMAND_VALID) begin
         if (alt_reg) begin
            STOP_COAST      <= 1'b0;
            STOP_RAMP       <= 1'b0;
            QUICK_RAMP      <= 1'b0;
            FREEZE_SETPOINT <= 1'b0;
            SETPOINT_ZERO   <= 1'b0;
            REMOTE_INPUTS   <= fixed_command_half[CMD_DIN_LO +: DIN_COUNT];
         end else begin
            STOP_COAST      <= fixed_command_half[CMD_DIN_LO];
            STOP_RAMP       <= fixed_command_half[CMD_DIN_LO+1];
            QUICK_RAMP      <= fixed_command_half[CMD_DIN_LO+2];
            FREEZE_SETPOINT <= fixed_command_half[CMD_DIN_LO+3];
            SETPOINT_ZERO   <= fixed_command_half[CMD_DIN_HI];
            REMOTE_INPUTS   <= '0;
         end
      end
   end

   // Fixed report flags in bit order B0..B7
   // Same clock domain as the drive logic, so no synchroniser in front
   assign rpt_if.flags = {MAGNETIZED,
                          ZERO_SPEED,
                          AT_REFERENCE,
                          ALARM_ACTIVE,
                          FAULT_ACTIVE,
                          MOTOR_CCW,
                          MOTOR_RUNNING,
                          DRIVE_READY};
   assign rpt_if.app   = APPLICATION_REPORT_HALF;

   // Word assembled in a registered builder, so status is one cycle late
   // The extra cycle keeps STATUS_WORD straight from a flop
   report_word_builder u_builder (
      .clk (CLK_SYS),
      .rst (RST),
      .rpt (rpt_if.dst)
   );

   assign STATUS_WORD = rpt_if.word;
endmodule

// ---- tb/fb_master.sv ----
`timescale 1ns/10ps
module fb_master
   import cmd_status_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              go,
   input  wire logic              rsv_ok,
   input  wire logic [WORD_W-1:0] word_in,
   output logic      [WORD_W-1:0] cmd_word = 32'h0000_0000,
   output logic                   cmd_valid = 1'b0
);
   // One word a request; idle bus toggles so a stale word never looks valid
   always_ff @(posedge clk) begin
      cmd_valid <= go;
      cmd_word  <= go ? (rsv_ok ? word_in : word_in & 32'hFFFF_1FFF) : ~cmd_word;
   end
endmodule

// ---- tb/drive_cmd_chk.sv ----
`timescale 1ns/10ps
module drive_cmd_chk
   import cmd_status_pkg::*;
#(parameter int DIN_COUNT = DIN_N)
(
   input wire logic                 CLK_SYS,
   input wire logic                 RST,
   input wire logic                 COMMAND_VALID,
   input wire logic                 ALT_VARIANT,
   input wire logic                 EVENT_CLEAR,
   input wire logic                 STOP_COAST,
   input wire logic                 QUICK_STOP,
   input wire logic                 JOG_REFERENCE_FIRST,
   input wire logic                 JOG_REFERENCE_SECOND,
   input wire logic                 DRIVE_READY,
   input wire logic                 MOTOR_RUNNING,
   input wire logic                 MOTOR_CCW,
   input wire logic                 FAULT_ACTIVE,
   input wire logic                 ALARM_ACTIVE,
   input wire logic                 AT_REFERENCE,
   input wire logic                 ZERO_SPEED,
   input wire logic                 MAGNETIZED,
   input wire logic [WORD_W-1:0]    COMMAND_WORD,
   input wire logic [WORD_W-1:0]    STATUS_WORD,
   input wire logic [HALF_W-1:0]    APPLICATION_REPORT_HALF,
   input wire logic [HALF_W-1:0]    APPLICATION_COMMAND_HALF,
   input wire logic [DIN_COUNT-1:0] REMOTE_INPUTS
);
   logic last_b2_reg;
   logic rise;
   // Edge of bit 2 is judged between taken words, so hold it in between
   always_ff @(posedge CLK_SYS) begin
      if (RST) last_b2_reg <= 1'b0;
      else if (COMMAND_VALID) last_b2_reg <= COMMAND_WORD[CMD_CLEAR];
   end
   assign rise = COMMAND_VALID && COMMAND_WORD[CMD_CLEAR] && !last_b2_reg;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_pulse; EVENT_CLEAR ##1 !EVENT_CLEAR; endsequence
   sequence s_take_gap; COMMAND_VALID ##1 !COMMAND_VALID; endsequence
   property p_clr; rise |=> s_pulse; endproperty
   a_clr: assert property (p_clr) else $error("no clear pulse");
   property p_noclr; !rise |=> !EVENT_CLEAR; endproperty
   a_noclr: assert property (p_noclr) else $error("stray clear");
   property p_jog; COMMAND_VALID |=>
      {JOG_REFERENCE_SECOND, JOG_REFERENCE_FIRST} == $past(COMMAND_WORD[CMD_JOG2:CMD_JOG1]);
   endproperty
   a_jog: assert property (p_jog) else $error("jog request wrong");
   property p_qstop; s_take_gap |=> QUICK_STOP == $past(COMMAND_WORD[CMD_QSTOP], 2); endproperty
   a_qstop: assert property (p_qstop) else $error("quick stop wrong");
   property p_app; COMMAND_VALID |=> APPLICATION_COMMAND_HALF == $past(COMMAND_WORD[31:16]);
   endproperty
   a_app: assert property (p_app) else $error("upper command half wrong");
   property p_stlo; 1'b1 |=> STATUS_WORD[RPT_FLAGS-1:0] == $past({MAGNETIZED, ZERO_SPEED,
      AT_REFERENCE, ALARM_ACTIVE, FAULT_ACTIVE, MOTOR_CCW, MOTOR_RUNNING, DRIVE_READY});
   endproperty
   a_stlo: assert property (p_stlo)
      else $error("status flags wrong");
   property p_sthi; 1'b1 |=>
      STATUS_WORD[WORD_W-1:RPT_FLAGS] == {$past(APPLICATION_REPORT_HALF), 8'h00};
   endproperty
   a_sthi: assert property (p_sthi) else $error("upper status wrong");
   // Strap flop holds 0 through reset, so the cycle after reset is excluded
   property p_din; COMMAND_VALID && ALT_VARIANT && $past(ALT_VARIANT) && !$past(RST) |=>
      REMOTE_INPUTS == $past(COMMAND_WORD[CMD_DIN_HI:CMD_DIN_LO]) && !STOP_COAST;
   endproperty
   a_din: assert property (p_din) else $error("remote inputs wrong");
   property p_stop; COMMAND_VALID && !$past(ALT_VARIANT) |=>
      STOP_COAST == $past(COMMAND_WORD[CMD_DIN_LO]) && REMOTE_INPUTS == '0;
   endproperty
   a_stop: assert property (p_stop) else $error("stop options wrong");
endmodule
bind drive_command_status_word drive_cmd_chk #(.DIN_COUNT(DIN_COUNT)) u_chk (.CLK_SYS, .RST,
   .COMMAND_VALID, .ALT_VARIANT, .EVENT_CLEAR, .STOP_COAST, .QUICK_STOP, .JOG_REFERENCE_FIRST,
   .JOG_REFERENCE_SECOND, .DRIVE_READY, .MOTOR_RUNNING, .MOTOR_CCW, .FAULT_ACTIVE,
   .ALARM_ACTIVE, .AT_REFERENCE, .ZERO_SPEED, .MAGNETIZED, .COMMAND_WORD, .STATUS_WORD,
   .APPLICATION_REPORT_HALF, .APPLICATION_COMMAND_HALF, .REMOTE_INPUTS);

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
   import cmd_status_pkg::*;
   ;
   logic CLK_SYS = 1'b0, RST = 1'b1, go = 1'b0, rsv_ok = 1'b0, alt = 1'b0, b2 = 1'b0;
   logic took = 1'b0, cmd_valid;
   logic [WORD_W-1:0] word_in = 32'h0000_0000, cmd_word;
   logic [23:0] stat = 24'h00_0000;
   logic [65:0] e, q[$];
   wire  [33:0] obs;
   wire  [WORD_W-1:0] stw;
   int miscompares = 0, checks_done = 0, cycles = 0;
   always #4 CLK_SYS = ~CLK_SYS;
   fb_master master (.clk(CLK_SYS), .go, .rsv_ok, .word_in, .cmd_word, .cmd_valid);
   drive_command_status_word uut (.CLK_SYS, .RST, .COMMAND_WORD(cmd_word),
      .COMMAND_VALID(cmd_valid), .ALT_VARIANT(alt), .DRIVE_READY(stat[0]),
      .MOTOR_RUNNING(stat[1]), .MOTOR_CCW(stat[2]), .FAULT_ACTIVE(stat[3]),
      .ALARM_ACTIVE(stat[4]), .AT_REFERENCE(stat[5]), .ZERO_SPEED(stat[6]),
      .MAGNETIZED(stat[7]), .APPLICATION_REPORT_HALF(stat[23:8]), .EVENT_CLEAR(obs[33]),
      .QUICK_STOP(obs[32]), .JOG_REFERENCE_SECOND(obs[31]), .JOG_REFERENCE_FIRST(obs[30]),
      .FIELDBUS_REFERENCE(obs[29]), .FIELDBUS_CONTROL(obs[28]), .REVERSE_REQUEST(obs[27]),
      .RUN_REQUEST(obs[26]), .REMOTE_INPUTS(obs[25:21]), .SETPOINT_ZERO(obs[20]),
      .FREEZE_SETPOINT(obs[19]), .QUICK_RAMP(obs[18]), .STOP_RAMP(obs[17]),
      .STOP_COAST(obs[16]), .APPLICATION_COMMAND_HALF(obs[15:0]), .STATUS_WORD(stw));
   task automatic report(input string m);
      $display("Error at %0t: %s", $time, m);
      miscompares++;
   endtask
   task automatic test_done();
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One word through the master, status changed while it is in flight
   task automatic step(input logic [WORD_W-1:0] w, input logic a, input logic r);
      logic [WORD_W-1:0] m;
      logic [23:0] s;
      m = r ? w : w & 32'hFFFF_1FFF;
      s = 24'($urandom);
      @(posedge CLK_SYS);
      go <= 1'b1;
      word_in <= w;
      alt <= a;
      rsv_ok <= r;
      @(posedge CLK_SYS);
      go <= 1'b0;
      stat <= s;
      q.push_back({m[CMD_CLEAR] & ~b2, m[12:8], m[1:0], a ? m[7:3] : 5'h00,
                   a ? 5'h00 : m[7:3], m[31:16], s[23:8], 8'h00, s[7:0]});
      b2 = m[CMD_CLEAR];
   endtask
   // Results land on the edge that takes the word; compare at the falling edge
   always @(posedge CLK_SYS) took <= cmd_valid && !RST;
   always @(negedge CLK_SYS) begin
      if (took) begin
         checks_done += 9;
         if (q.size() == 0) report("no expected note");
         else begin
            e = q.pop_front();
            if (obs[33] !== e[65]) report("clear pulse differs");
            if (obs[32:30] !== e[64:62]) report("jog or stop differs");
            if (obs[29:26] !== e[61:58]) report("run or place differs");
            if (obs[25:16] !== e[57:48]) report("bits 3 to 7 differ");
            if (obs[15:0] !== e[47:32]) report("upper command half differs");
            if (stw[3:0] !== e[3:0]) report("status B0-B3 differ");
            if (stw[7:4] !== e[7:4]) report("status B4-B7 differ");
            if (stw[15:8] !== e[15:8]) report("reserved status set");
            if (stw[31:16] !== e[31:16]) report("upper status differs");
         end
      end
   end
   // Hang guard, far above the 167 cycles the run needs
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         test_done();
      end
   end
   // Random words cover both variants, reserved bits and bit 2 edges and levels
   initial begin
      void'($urandom(18927));
      repeat (3) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int i = 0; i < 80; i++) step($urandom, i[3], i[2:0] == 3'h5);
      repeat (4) @(posedge CLK_SYS);
      test_done();
   end
endmodule
